// ---- fsl_pkg.sv ----
package fsl_pkg;
  // ****************************************
  // register port map
  // ****************************************
  localparam logic [3:0] FSL_OFF_CTRL = 4'h0;
  localparam logic [3:0] FSL_OFF_STAT = 4'h4;
  localparam logic [3:0] FSL_OFF_FEAT = 4'h8;
  localparam logic [3:0] FSL_OFF_TAGS = 4'hC;
  localparam int FSL_CTRL_EN = 0;
  localparam int FSL_CTRL_CMOV = 1;
  localparam logic [1:0] FSL_CTRL_RST = 2'h3;
  localparam int FSL_STAT_INV = 0;
  localparam int FSL_STAT_DEN = 1;
  localparam int FSL_STAT_STK = 2;
  localparam int FSL_STAT_NOTFP = 3;
  localparam int FSL_STAT_TOP_LSB = 8;
  localparam logic [3:0] FSL_FLAGS_RST = 4'h0;
  localparam logic [2:0] FSL_TOP_RST = 3'h0;
  localparam logic [7:0] FSL_TAG_RST = 8'hFF;
  // ****************************************
  // opcode class and number formats
  // ****************************************
  localparam logic [7:0] FSL_ESCAPE_LO = 8'hD8;
  localparam logic [7:0] FSL_ESCAPE_HI = 8'hDF;
  localparam logic [14:0] FSL_EXP_MAX = 15'h7FFF;
  localparam logic [14:0] FSL_EXP_ONE = 15'h0001;
  localparam logic [14:0] FSL_EXT_BIAS = 15'h3FFF;
  localparam logic [14:0] FSL_F32_REBIAS = 15'h3F80;
  localparam logic [14:0] FSL_F32_DEN_EXP = 15'h3F81;
  localparam logic [14:0] FSL_F64_REBIAS = 15'h3C00;
  localparam logic [14:0] FSL_F64_DEN_EXP = 15'h3C01;
  localparam logic signed [16:0] FSL_F32_BIAS = 17'sh007F;
  localparam logic signed [16:0] FSL_F64_BIAS = 17'sh03FF;
  localparam logic signed [16:0] FSL_BCD_LIM = 17'sh003C;
  localparam logic [79:0] FSL_QNAN_IND = 80'hFFFF_C000_0000_0000_0000;
  localparam logic [79:0] FSL_BCD_IND = 80'hFFFF_C000_0000_0000_0000;

  typedef enum logic [3:0] {
    LOAD_FLOAT_PUSH, LOAD_INTEGER_PUSH, LOAD_DECIMAL_PUSH, STORE_FLOAT, STORE_INTEGER,
    STORE_FLOAT_POP, STORE_INTEGER_POP, STORE_DECIMAL_POP, SWAP_WITH_STACK_TOP, CONDITIONAL_FLOAT_MOVE
  } fsl_op_t;
  typedef enum logic [2:0] {FMT_F32, FMT_F64, FMT_F80, FMT_I16, FMT_I32, FMT_I64, FMT_BCD} fsl_fmt_t;
  typedef enum logic [2:0] {CC_B, CC_NB, CC_E, CC_NE, CC_BE, CC_NBE, CC_U, CC_NU} fsl_cond_t;

  typedef struct packed {
    logic [7:0] opcode;
    fsl_op_t op;
    fsl_fmt_t fmt;
    logic use_reg;
    logic [2:0] idx;
    fsl_cond_t cond;
    logic imm_present;
    logic [79:0] mem_data;
  } fsl_cmd_t;
  typedef struct packed {
    logic carry_flag_bit;
    logic zero_flag_bit;
    logic parity_flag_bit;
  } fsl_flags_t;
  typedef struct packed {
    fsl_fmt_t fmt;
    logic [79:0] data;
  } fsl_store_t;
  typedef struct packed {
    logic inv;
    logic den;
    logic [79:0] val;
  } fsl_conv_t;
endpackage : fsl_pkg

// ---- fsl_unit.sv ----
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Contract
// - pseudo-NaN, pseudo-infinity and unnormal operands raise invalid-operation.
// - never produce a pseudo-denormal result.
// - pseudo-denormal operand accepted, exponent taken as one, mantissa kept.
// - pseudo-denormal operand also sets the denormal-operand flag.
// - first opcode byte D8H..DFH marks the floating escape class.
// - no immediate operands; stack or memory only, at most two.
// - register operands are offsets from the stack top pointer.
// - float load pushes, widening single and double to extended.
// - float load may push a copy of a stack register.
// - integer and decimal loads convert to extended and push.
// - non-popping stores write converted top to memory, stack unchanged; the non-popping float store may instead copy top into a stack register.
// - pop tags the top register empty and adds one to top.
// - popping float store may copy top into a stack register.
// - swap exchanges a selected register with the top register.
// - conditional move copies register into top only when condition holds.
// - move conditions come from carry, zero and parity flags.
// - conditional move support is reported through feature identification.
// - all non-extended formats are converted to extended on load.
module fsl_unit import fsl_pkg::*; #(
  parameter logic P_CMOV_SUPPORTED = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_cmd_valid,
  input wire fsl_cmd_t i_cmd,
  output logic o_cmd_ready,
  input wire fsl_flags_t i_flags,
  output logic o_st_valid,
  output fsl_store_t o_st,
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  typedef enum {S_IDLE, S_POP} fsl_state_t;

  // ****************************************
  // number conversion
  // ****************************************
  function automatic logic [6:0] fsl_clz(input logic [63:0] v);
    logic [6:0] n;
    n = 7'h40;
    for (int k = 0; k < 64; k++) begin
      if (v[k]) n = 7'(63 - k);
    end
    return n;
  endfunction : fsl_clz

  function automatic logic [79:0] fsl_int_ext(input logic s, input logic [63:0] mag);
    logic [6:0] lz;
    lz = fsl_clz(mag);
    if (mag == 64'h0) return 80'h0;
    return {s, 15'(FSL_EXT_BIAS + 15'h003F - 15'(lz)), mag << lz};
  endfunction : fsl_int_ext

  // memory image to extended; a pseudo-denormal input gets exponent one, so never a pseudo-denormal
  function automatic fsl_conv_t fsl_to_ext(input fsl_fmt_t f, input logic [79:0] d);
    fsl_conv_t r;
    logic [63:0] v;
    logic [63:0] m;
    logic [6:0] lz;
    r = '0;
    v = 64'h0;
    m = 64'h0;
    lz = 7'h0;
    case (f)
      FMT_F32: begin
        m = {1'b0, d[22:0], 40'h0};
        lz = fsl_clz(m);
        if (d[30:23] == 8'hFF) r.val = {d[31], FSL_EXP_MAX, 1'b1, d[22:0], 40'h0};
        else if (d[30:23] != 8'h00) r.val = {d[31], 15'(d[30:23]) + FSL_F32_REBIAS, 1'b1, d[22:0], 40'h0};
        else if (m != 64'h0) r = '{1'b0, 1'b1, {d[31], FSL_F32_DEN_EXP - 15'(lz), m << lz}};
        else r.val = {d[31], 79'h0};
      end
      FMT_F64: begin
        m = {1'b0, d[51:0], 11'h0};
        lz = fsl_clz(m);
        if (d[62:52] == 11'h7FF) r.val = {d[63], FSL_EXP_MAX, 1'b1, d[51:0], 11'h0};
        else if (d[62:52] != 11'h000) r.val = {d[63], 15'(d[62:52]) + FSL_F64_REBIAS, 1'b1, d[51:0], 11'h0};
        else if (m != 64'h0) r = '{1'b0, 1'b1, {d[63], FSL_F64_DEN_EXP - 15'(lz), m << lz}};
        else r.val = {d[63], 79'h0};
      end
      FMT_F80: begin
        if (d[78:64] != 15'h0 && !d[63]) r = '{1'b1, 1'b0, FSL_QNAN_IND};
        else if (d[78:64] == 15'h0 && d[63]) r = '{1'b0, 1'b1, {d[79], FSL_EXP_ONE, d[63:0]}};
        else r.val = d;
      end
      FMT_BCD: begin
        for (int k = 17; k >= 0; k--) begin
          v = v * 64'h000A + 64'(d[4*k+:4]);
        end
        r.val = fsl_int_ext(d[79], v);
      end
      default: begin
        if (f == FMT_I16) v = {{48{d[15]}}, d[15:0]};
        else if (f == FMT_I32) v = {{32{d[31]}}, d[31:0]};
        else v = d[63:0];
        r.val = fsl_int_ext(v[63], v[63] ? (~v + 64'h1) : v);
      end
    endcase
    return r;
  endfunction : fsl_to_ext

  // extended to memory image; fractions are truncated toward zero
  function automatic fsl_conv_t fsl_from_ext(input fsl_fmt_t f, input logic [79:0] x);
    fsl_conv_t r;
    logic signed [16:0] ue;
    logic signed [16:0] lim;
    logic [63:0] mag;
    logic [63:0] v;
    logic [71:0] bcd;
    r = '0;
    ue = $signed({2'b00, x[78:64]}) - $signed({2'b00, FSL_EXT_BIAS});
    lim = (f == FMT_I16) ? 17'sh000F : (f == FMT_I32) ? 17'sh001F : (f == FMT_BCD) ? FSL_BCD_LIM : 17'sh003F;
    mag = (ue < 0 || ue > 17'sh003F) ? 64'h0 : x[63:0] >> 6'(17'sh003F - ue);
    v = x[79] ? (~mag + 64'h1) : mag;
    bcd = 72'h0;
    case (f)
      FMT_F32: begin
        if (x[78:64] == FSL_EXP_MAX) r.val = {48'h0, x[79], 8'hFF, x[62:40]};
        else if (x[78:64] == 15'h0 || ue <= -FSL_F32_BIAS) r.val = {48'h0, x[79], 31'h0};
        else if (ue > FSL_F32_BIAS) r.val = {48'h0, x[79], 8'hFF, 23'h0};
        else r.val = {48'h0, x[79], 8'(ue + FSL_F32_BIAS), x[62:40]};
      end
      FMT_F64: begin
        if (x[78:64] == FSL_EXP_MAX) r.val = {16'h0, x[79], 11'h7FF, x[62:11]};
        else if (x[78:64] == 15'h0 || ue <= -FSL_F64_BIAS) r.val = {16'h0, x[79], 63'h0};
        else if (ue > FSL_F64_BIAS) r.val = {16'h0, x[79], 11'h7FF, 52'h0};
        else r.val = {16'h0, x[79], 11'(ue + FSL_F64_BIAS), x[62:11]};
      end
      FMT_F80: r.val = x;
      FMT_BCD: begin
        for (int b = 63; b >= 0; b--) begin
          for (int k = 0; k < 18; k++) begin
            if (bcd[4*k+:4] >= 4'h5) bcd[4*k+:4] = bcd[4*k+:4] + 4'h3;
          end
          bcd = {bcd[70:0], mag[b]};
        end
        if (x[78:64] == FSL_EXP_MAX || ue >= lim) r = '{1'b1, 1'b0, FSL_BCD_IND};
        else r.val = {x[79], 7'h0, bcd};
      end
      default: begin
        if (x[78:64] == FSL_EXP_MAX || ue >= lim) r.inv = 1'b1;
        if (f == FMT_I16) r.val = r.inv ? 80'h8000 : {64'h0, v[15:0]};
        else if (f == FMT_I32) r.val = r.inv ? 80'h8000_0000 : {48'h0, v[31:0]};
        else r.val = r.inv ? 80'h8000_0000_0000_0000 : {16'h0, v};
      end
    endcase
    return r;
  endfunction : fsl_from_ext

  // ****************************************
  // state
  // ****************************************
  fsl_state_t state_q, state_d;
  logic [79:0] regs_q [8];
  logic [79:0] regs_d [8];
  logic [7:0] tag_q, tag_d;
  logic [2:0] top_q, top_d;
  logic [1:0] ctrl_q;
  logic [3:0] flags_q;
  logic [3:0] flags_set;
  logic st_valid_q;
  fsl_store_t st_q;
  logic [31:0] rdata_q;

  // ****************************************
  // decode
  // ****************************************
  wire logic cmov_en = ctrl_q[FSL_CTRL_CMOV] & P_CMOV_SUPPORTED;
  wire logic accept = i_ce & i_cmd_valid & o_cmd_ready;
  wire logic is_fp = (i_cmd.opcode >= FSL_ESCAPE_LO) && (i_cmd.opcode <= FSL_ESCAPE_HI);
  wire logic is_cmov = i_cmd.op == CONDITIONAL_FLOAT_MOVE;
  // an immediate never reaches the datapath; only stack or memory operands exist
  wire logic cmd_bad = !is_fp | i_cmd.imm_present | (is_cmov & !cmov_en);
  wire logic go = accept & !cmd_bad;
  wire logic [2:0] src_phys = top_q + i_cmd.idx;
  wire logic [2:0] push_phys = top_q - 3'h1;
  wire logic is_push = i_cmd.op inside {LOAD_FLOAT_PUSH, LOAD_INTEGER_PUSH, LOAD_DECIMAL_PUSH};
  wire logic is_pop = i_cmd.op inside {STORE_FLOAT_POP, STORE_INTEGER_POP, STORE_DECIMAL_POP};
  wire logic is_store = is_pop | (i_cmd.op inside {STORE_FLOAT, STORE_INTEGER});
  wire logic fl_reg = i_cmd.use_reg & (i_cmd.op inside {LOAD_FLOAT_PUSH, STORE_FLOAT, STORE_FLOAT_POP});
  wire logic st_mem = is_store & !fl_reg;
  wire logic ld_mem = is_push & !fl_reg;
  wire logic top_empty = tag_q[top_q];
  wire logic src_empty = tag_q[src_phys];
  wire fsl_conv_t ld_conv = fsl_to_ext(i_cmd.fmt, i_cmd.mem_data);
  wire logic [79:0] top_val = top_empty ? FSL_QNAN_IND : regs_q[top_q];
  wire fsl_conv_t st_conv = fsl_from_ext(i_cmd.fmt, top_val);
  wire logic [79:0] push_val = fl_reg ? regs_q[src_phys] : ld_conv.val;
  wire logic push_fault = !tag_q[push_phys] | (fl_reg & src_empty);
  wire logic cf = i_flags.carry_flag_bit;
  wire logic zf = i_flags.zero_flag_bit;
  wire logic pf = i_flags.parity_flag_bit;
  // condition decode straight from the core's status flags
  wire logic cond_true = (i_cmd.cond == CC_B) ? cf : (i_cmd.cond == CC_NB) ? !cf :
    (i_cmd.cond == CC_E) ? zf : (i_cmd.cond == CC_NE) ? !zf :
    (i_cmd.cond == CC_BE) ? (cf | zf) : (i_cmd.cond == CC_NBE) ? !(cf | zf) :
    (i_cmd.cond == CC_U) ? pf : !pf;

  assign o_cmd_ready = (state_q == S_IDLE) & ctrl_q[FSL_CTRL_EN];
  assign flags_set[FSL_STAT_INV] = go & ((ld_mem & ld_conv.inv) | (st_mem & st_conv.inv));
  assign flags_set[FSL_STAT_DEN] = go & ld_mem & ld_conv.den;
  assign flags_set[FSL_STAT_STK] = go & ((is_push & push_fault) | (!is_push & top_empty) |
    ((is_cmov | i_cmd.op == SWAP_WITH_STACK_TOP) & src_empty));
  assign flags_set[FSL_STAT_NOTFP] = accept & cmd_bad;

  // ****************************************
  // stack next state
  // ****************************************
  // the pop of a popping store waits one cycle so the memory write leaves first
  always_comb begin
    regs_d = regs_q;
    tag_d = tag_q;
    top_d = top_q;
    state_d = state_q;
    if (state_q == S_POP) begin
      tag_d[top_q] = 1'b1;
      top_d = top_q + 3'h1;
      state_d = S_IDLE;
    end else if (go) begin
      if (is_push) begin
        regs_d[push_phys] = push_fault ? FSL_QNAN_IND : push_val;
        tag_d[push_phys] = 1'b0;
        top_d = push_phys;
      end else if (is_store) begin
        if (fl_reg) begin
          regs_d[src_phys] = top_val;
          tag_d[src_phys] = 1'b0;
        end
        if (is_pop) state_d = S_POP;
      end else if (i_cmd.op == SWAP_WITH_STACK_TOP) begin
        regs_d[top_q] = regs_q[src_phys];
        regs_d[src_phys] = regs_q[top_q];
        tag_d[top_q] = tag_q[src_phys];
        tag_d[src_phys] = tag_q[top_q];
      end else if (is_cmov && cond_true) begin
        regs_d[top_q] = regs_q[src_phys];
        tag_d[top_q] = tag_q[src_phys];
      end
    end
  end

  // ****************************************
  // register port
  // ****************************************
  wire logic wr_ctrl = i_reg_wr & (i_reg_addr == FSL_OFF_CTRL);
  wire logic wr_stat = i_reg_wr & (i_reg_addr == FSL_OFF_STAT);
  wire logic [3:0] flags_clr = wr_stat ? i_reg_wdata[3:0] : 4'h0;
  logic [31:0] rd_mux;
  always_comb begin
    if (i_reg_addr == FSL_OFF_CTRL) rd_mux = {30'h0, ctrl_q};
    else if (i_reg_addr == FSL_OFF_STAT) rd_mux = {21'h0, top_q, 4'h0, flags_q};
    else if (i_reg_addr == FSL_OFF_FEAT) rd_mux = {31'h0, P_CMOV_SUPPORTED};
    else if (i_reg_addr == FSL_OFF_TAGS) rd_mux = {24'h0, tag_q};
    else rd_mux = 32'h0; // unmapped reads return zero
  end

  // ****************************************
  // flops
  // ****************************************
  // all state holds while the clock enable is low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= S_IDLE;
      tag_q <= FSL_TAG_RST;
      top_q <= FSL_TOP_RST;
      for (int k = 0; k < 8; k++) regs_q[k] <= 80'h0;
    end else if (i_ce) begin
      state_q <= state_d;
      tag_q <= tag_d;
      top_q <= top_d;
      regs_q <= regs_d;
    end
  end

  // set beats a same-cycle write-one-to-clear so no event is lost
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q <= FSL_CTRL_RST;
      flags_q <= FSL_FLAGS_RST;
      rdata_q <= 32'h0;
    end else if (i_ce) begin
      if (wr_ctrl) ctrl_q <= i_reg_wdata[1:0];
      flags_q <= (flags_q & ~flags_clr) | flags_set;
      rdata_q <= i_reg_rd ? rd_mux : 32'h0;
    end
  end

  // store data leave one cycle after the command
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_valid_q <= 1'b0;
      st_q <= '0;
    end else if (i_ce) begin
      st_valid_q <= go & st_mem;
      if (go & st_mem) st_q <= '{i_cmd.fmt, st_conv.val};
    end
  end

  assign o_st_valid = st_valid_q;
  assign o_st = st_q;
  assign o_reg_rdata = rdata_q;

  // ****************************************
  // checks
  // ****************************************
  wire logic ld_bad = go & ld_mem & i_cmd.fmt == FMT_F80 & i_cmd.mem_data[78:64] != 15'h0 & !i_cmd.mem_data[63];
  wire logic ld_pden = go & ld_mem & i_cmd.fmt == FMT_F80 & i_cmd.mem_data[78:64] == 15'h0 & i_cmd.mem_data[63];
  sequence s_store_pop;
    go & is_pop & !fl_reg ##1 i_ce;
  endsequence
  sequence s_pop_done;
    top_q == $past(top_q) + 3'h1 && tag_q[$past(top_q)];
  endsequence

  a_escape_screen: assert property (accept & !is_fp |=> flags_q[FSL_STAT_NOTFP] && $stable(top_q))
    else $error("non-escape opcode changed the stack");
  a_no_immediate: assert property (accept & i_cmd.imm_present |=> !o_st_valid && flags_q[FSL_STAT_NOTFP])
    else $error("immediate operand was not refused");
  a_push_top: assert property (go & is_push |=> top_q == $past(top_q) - 3'h1 && !tag_q[top_q])
    else $error("push did not move top down by one");
  a_pseudo_trap: assert property (ld_bad |=> flags_q[FSL_STAT_INV] && regs_q[top_q] == FSL_QNAN_IND)
    else $error("unsupported encoding not trapped");
  a_pseudo_denorm: assert property (ld_pden |=> flags_q[FSL_STAT_DEN] && regs_q[top_q][78:64] == FSL_EXP_ONE
    && regs_q[top_q][63:0] == $past(i_cmd.mem_data[63:0]))
    else $error("pseudo-denormal not reinterpreted");
  a_no_pseudo_den: assert property (!(regs_q[top_q][78:64] == 15'h0 && regs_q[top_q][63]))
    else $error("pseudo-denormal in stack top");
  a_store_then_pop: assert property (s_store_pop |-> o_st_valid && top_q == $past(top_q) ##1 s_pop_done)
    else $error("popping store order broken");
  a_store_keeps: assert property (go & st_mem & !is_pop |=> o_st_valid && $stable(top_q) && $stable(tag_q))
    else $error("plain store disturbed the stack");
  a_cmov_false: assert property (go & is_cmov & !cond_true |=> regs_q[top_q] == $past(regs_q[top_q]))
    else $error("false condition moved data");
  a_swap_pair: assert property (go & i_cmd.op == SWAP_WITH_STACK_TOP |=>
    regs_q[top_q] == $past(regs_q[src_phys]))
    else $error("swap did not fill the top");
endmodule : fsl_unit

// ---- fsl_mem_model.sv ----
`timescale 1ns/1ps
// ****************************************
// memory operand path partner
// ****************************************
module fsl_mem_model import fsl_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_st_valid,
  input wire fsl_store_t i_st,
  output fsl_store_t o_last,
  output logic [15:0] o_count
);
  // keep each store write as it lands; the count shows writes that never came or came twice
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_last <= '0;
      o_count <= 16'h0;
    end else if (i_st_valid) begin
      o_last <= i_st;
      o_count <= o_count + 16'h1;
    end
  end
endmodule : fsl_mem_model

// ---- fsl_unit_tb_top.sv ----
`timescale 1ns/1ps
module fsl_unit_tb_top import fsl_pkg::*; ;
  logic i_clk, i_rst, i_ce, i_cmd_valid, o_cmd_ready, o_st_valid, i_reg_wr, i_reg_rd;
  fsl_cmd_t i_cmd;
  fsl_flags_t i_flags;
  fsl_store_t o_st, mem_last;
  logic [15:0] mem_count;
  logic [3:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, rd;
  logic [79:0] va, vb;
  int bad_count, checks;
  localparam logic [79:0] ONE = 80'h3FFF_8000_0000_0000_0000;
  fsl_op_t lop [6] = '{LOAD_FLOAT_PUSH, LOAD_FLOAT_PUSH, LOAD_INTEGER_PUSH, LOAD_INTEGER_PUSH,
    LOAD_INTEGER_PUSH, LOAD_DECIMAL_PUSH};
  fsl_fmt_t lfm [6] = '{FMT_F32, FMT_F64, FMT_I16, FMT_I32, FMT_I64, FMT_BCD};
  logic [79:0] lsrc [6] = '{80'h3F80_0000, 80'h3FF0_0000_0000_0000, 80'h1, 80'h1, 80'h1, 80'h1};
  logic [79:0] bad [3] = '{80'h7FFF_0000_0000_0000_0000, 80'h7FFF_4000_0000_0000_0000,
    80'h3FFF_0000_0000_0000_0001};
  logic [7:0] nopc [3] = '{8'hD7, 8'hE0, 8'hDC};

  fsl_unit u_fsl_unit (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .i_flags(i_flags), .o_st_valid(o_st_valid),
    .o_st(o_st), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
  fsl_mem_model u_fsl_mem_model (.i_clk(i_clk), .i_rst(i_rst), .i_st_valid(o_st_valid), .i_st(o_st),
    .o_last(mem_last), .o_count(mem_count));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ****************************************
  // access tasks
  // ****************************************
  task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe, so sample there
  task automatic reg_rd(input logic [3:0] a);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    rd = o_reg_rdata;
  endtask : reg_rd

  // hold the command until an edge sees ready high; bounded so a stuck unit ends the run
  task automatic cmd(input fsl_op_t op, input fsl_fmt_t fm, input logic [79:0] d, input logic u = 1'b0,
    input logic [2:0] ix = 3'h0, input fsl_cond_t cc = CC_B, input logic [7:0] opc = 8'hD9,
    input logic im = 1'b0);
    int n;
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= '{opc, op, fm, u, ix, cc, im, d};
    for (n = 0; n < 20; n++) begin
      #1;
      if (o_cmd_ready === 1'b1) break;
      @(posedge i_clk);
    end
    if (n == 20) begin
      bad_count++;
      conclude();
    end
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
  endtask : cmd

  task automatic sto(input fsl_op_t op, input fsl_fmt_t fm, input logic [79:0] e, input logic u = 1'b0,
    input logic [2:0] ix = 3'h0);
    logic pop;
    pop = (op == STORE_FLOAT_POP || op == STORE_INTEGER_POP || op == STORE_DECIMAL_POP);
    cmd(op, fm, 80'h0, u, ix);
    #1;
    if (pop) check("ready_pop", o_cmd_ready, 1'b0);
    check("st_valid", o_st_valid, !u);
    @(posedge i_clk);
    #1;
    if (pop) check("ready_back", o_cmd_ready, 1'b1);
    if (!u) check("st_data", mem_last.data, e);
    if (!u) check("st_fmt", mem_last.fmt, fm);
  endtask : sto

  task automatic stack_is(input logic [2:0] t, input logic [7:0] g);
    reg_rd(FSL_OFF_STAT);
    check("top", rd[FSL_STAT_TOP_LSB+:3], t);
    reg_rd(FSL_OFF_TAGS);
    check("tags", rd[7:0], g);
  endtask : stack_is

  function automatic logic holds(input fsl_cond_t c, input fsl_flags_t f);
    case (c)
      CC_B: return f.carry_flag_bit;
      CC_NB: return !f.carry_flag_bit;
      CC_E: return f.zero_flag_bit;
      CC_NE: return !f.zero_flag_bit;
      CC_BE: return f.carry_flag_bit | f.zero_flag_bit;
      CC_NBE: return !f.carry_flag_bit & !f.zero_flag_bit;
      CC_U: return f.parity_flag_bit;
      default: return !f.parity_flag_bit;
    endcase
  endfunction : holds

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd = '0;
    i_flags = '0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 4'h0;
    i_reg_wdata = 32'h0;
    va = 80'h4000_C000_0000_0000_0000;
    vb = 80'hC001_A000_0000_0000_0000;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    reg_rd(FSL_OFF_CTRL);
    check("ctrl", rd, 32'h3);
    reg_rd(FSL_OFF_FEAT);
    check("feature", rd[0], 1'b1);
    reg_rd(4'h2);
    check("unmapped", rd, 32'h0);
    stack_is(3'h0, 8'hFF);
    $display("reset test done");
    // push, plain store leaves the stack alone, then every load format
    cmd(LOAD_FLOAT_PUSH, FMT_F80, va);
    stack_is(3'h7, 8'h7F);
    sto(STORE_FLOAT, FMT_F80, va);
    stack_is(3'h7, 8'h7F);
    for (int k = 0; k < 6; k++) begin
      cmd(lop[k], lfm[k], lsrc[k]);
      sto(STORE_FLOAT_POP, FMT_F80, ONE);
    end
    stack_is(3'h7, 8'h7F);
    cmd(LOAD_FLOAT_PUSH, FMT_F80, 80'h0, 1'b1, 3'h0);
    sto(STORE_FLOAT_POP, FMT_F80, va);
    $display("load store test done");
    // swap a stack-relative register with the top and back again
    cmd(LOAD_FLOAT_PUSH, FMT_F80, vb);
    cmd(SWAP_WITH_STACK_TOP, FMT_F80, 80'h0, 1'b1, 3'h1);
    sto(STORE_FLOAT, FMT_F80, va);
    cmd(SWAP_WITH_STACK_TOP, FMT_F80, 80'h0, 1'b1, 3'h1);
    sto(STORE_FLOAT, FMT_F80, vb);
    // the top holds minus five: narrow it to single and double on the way out
    sto(STORE_FLOAT, FMT_F32, 80'hC0A0_0000);
    sto(STORE_FLOAT, FMT_F64, 80'hC014_0000_0000_0000);
    // every condition against every flag pattern; the top is rebuilt after each move
    for (int c = 0; c < 8; c++) begin
      for (int f = 0; f < 8; f++) begin
        @(posedge i_clk);
        i_flags <= f[2:0];
        cmd(CONDITIONAL_FLOAT_MOVE, FMT_F80, 80'h0, 1'b1, 3'h1, fsl_cond_t'(c));
        sto(STORE_FLOAT_POP, FMT_F80, holds(fsl_cond_t'(c), fsl_flags_t'(f[2:0])) ? va : vb);
        cmd(LOAD_FLOAT_PUSH, FMT_F80, vb);
      end
    end
    $display("swap and move test done");
    sto(STORE_FLOAT_POP, FMT_F80, 80'h0, 1'b1, 3'h1);
    stack_is(3'h7, 8'h7F);
    sto(STORE_FLOAT, FMT_F80, vb);
    sto(STORE_INTEGER, FMT_I16, 80'hFFFB);
    cmd(LOAD_DECIMAL_PUSH, FMT_BCD, 80'h25);
    sto(STORE_DECIMAL_POP, FMT_BCD, 80'h25);
    sto(STORE_INTEGER_POP, FMT_I32, 80'hFFFF_FFFB);
    stack_is(3'h0, 8'hFF);
    // odd extended encodings
    reg_wr(FSL_OFF_STAT, 32'hF);
    cmd(LOAD_FLOAT_PUSH, FMT_F80, 80'h0000_8000_0000_0000_0001);
    reg_rd(FSL_OFF_STAT);
    check("den_flag", rd[FSL_STAT_DEN:FSL_STAT_INV], 2'b10);
    sto(STORE_FLOAT_POP, FMT_F80, 80'h0001_8000_0000_0000_0001);
    for (int k = 0; k < 3; k++) begin
      reg_wr(FSL_OFF_STAT, 32'hF);
      cmd(LOAD_FLOAT_PUSH, FMT_F80, bad[k]);
      reg_rd(FSL_OFF_STAT);
      check("inv_flag", rd[FSL_STAT_INV], 1'b1);
      sto(STORE_FLOAT_POP, FMT_F80, FSL_QNAN_IND);
    end
    $display("encoding test done");
    // refused commands: outside the escape range, or carrying an immediate
    for (int k = 0; k < 3; k++) begin
      reg_wr(FSL_OFF_STAT, 32'hF);
      cmd(LOAD_FLOAT_PUSH, FMT_F80, va, 1'b0, 3'h0, CC_B, nopc[k], k == 2);
      reg_rd(FSL_OFF_STAT);
      check("refused", rd[FSL_STAT_NOTFP], 1'b1);
      check("top_kept", rd[FSL_STAT_TOP_LSB+:3], 3'h0);
    end
    reg_wr(FSL_OFF_STAT, 32'hF);
    cmd(LOAD_FLOAT_PUSH, FMT_F80, va, 1'b0, 3'h0, CC_B, FSL_ESCAPE_LO);
    cmd(LOAD_FLOAT_PUSH, FMT_F80, vb, 1'b0, 3'h0, CC_B, FSL_ESCAPE_HI);
    reg_rd(FSL_OFF_STAT);
    check("edge_taken", rd[FSL_STAT_NOTFP], 1'b0);
    check("edge_top", rd[FSL_STAT_TOP_LSB+:3], 3'h6);
    // move turned off must be refused even with its condition true
    reg_wr(FSL_OFF_CTRL, 32'h1);
    cmd(CONDITIONAL_FLOAT_MOVE, FMT_F80, 80'h0, 1'b1, 3'h1, CC_B);
    reg_rd(FSL_OFF_STAT);
    check("move_off", rd[FSL_STAT_NOTFP], 1'b1);
    reg_wr(FSL_OFF_CTRL, 32'h3);
    sto(STORE_FLOAT_POP, FMT_F80, vb);
    sto(STORE_FLOAT_POP, FMT_F80, va);
    // a frozen unit takes nothing even while ready stays high
    @(posedge i_clk);
    i_ce <= 1'b0;
    cmd(LOAD_FLOAT_PUSH, FMT_F80, va);
    i_ce <= 1'b1;
    stack_is(3'h0, 8'hFF);
    check("store_count", mem_count, 16'h56);
    $display("refusal test done");
    conclude();
  end
endmodule : fsl_unit_tb_top
